// file: pkg/rbd_pkg.sv
// constants for the reset and boot dispatch block
// assumes one 50 MHz system clock and a synchronous active-low reset
package rbd_pkg;

	// ==========================================
	// clock and timing
	localparam int CLK_MHZ            = 50;
	localparam int RST_STRETCH_NS     = 1000;
	localparam int RST_STRETCH_CYC    = (RST_STRETCH_NS * CLK_MHZ + 999) / 1000;

	// ==========================================
	// reset source bit positions
	localparam int SRC_POR            = 0;
	localparam int SRC_PIN            = 1;
	localparam int SRC_CMP            = 2;
	localparam int SRC_SW             = 3;
	localparam int SRC_SUPPLY         = 4;
	localparam int SRC_GUARD          = 5;
	localparam int SRC_MCD            = 6;
	localparam int SRC_FLASH          = 7;
	localparam int SRC_COUNT          = 8;

	// ==========================================
	// boot dispatch
	localparam logic [7:0]  BOOT_SIG_PRESENT = 8'ha5;
	localparam logic [15:0] RESET_VECTOR     = 16'h0000;
	localparam logic [15:0] BOOT_VECTOR_DEF  = 16'hf800;

	// ==========================================
	// reset values
	localparam logic [1:0]  CLK_SEL_INTERNAL = 2'h0;
	localparam logic [2:0]  GUARD_TMO_MAX    = 3'h7;
	localparam logic [7:0]  PORT_LATCH_RST   = 8'hff;

	typedef enum logic [1:0] {
		RBD_RUN,
		RBD_HOLD,
		RBD_RELEASE
	} rbd_state_t;

endpackage

// file: verilog/rbd_top.sv
// reset collection, reset state control and boot vector dispatch
// assumes all reset sources are asynchronous to CLK and level or pulse
// assumes each source stays up for at least two CLK periods
// assumes the signature byte is stable whenever the block leaves reset
`timescale 1ns/1ps
module rbd_top
	import rbd_pkg::*;
#(
	parameter int             PORT_W      = $bits(PORT_LATCH_RST),
	parameter int             STRETCH_CYC = RST_STRETCH_CYC,
	parameter logic [15:0]    BOOT_VECTOR = BOOT_VECTOR_DEF
)
(
	input  wire logic                 CLK,              // system clock
	input  wire logic                 RST_B,            // synchronous reset, low
	input  wire logic                 POR_N,            // power-on detector, low
	input  wire logic                 EXT_RESET_PIN_N_I,// external reset pin level
	input  wire logic                 CMP_RESET,        // comparator reset request
	input  wire logic                 SW_RESET,         // software reset request
	input  wire logic                 SUPPLY_LOW,       // supply monitor trip
	input  wire logic                 GUARD_OVF,        // guard timer overflow
	input  wire logic                 CLK_MISSING,      // missing clock detect
	input  wire logic                 FLASH_ERR,        // flash error
	input  wire logic [7:0]           BOOT_SIG,         // signature byte below lock
	input  wire logic                 RETAIN_EN,        // firmware retention enable
	output logic                      EXT_RESET_PIN_N_O,// pin output level
	output logic                      EXT_RESET_PIN_N_OE,// pin drive enable
	output logic                      CORE_HALT,        // stop fetch and execute
	output logic                      REG_RST,          // module register reset
	output logic                      REG_POR_RST,      // power-on-only bits reset
	output logic                      IRQ_DISABLE,      // all interrupts off
	output logic                      TIMER_DISABLE,    // all timers off
	output logic                      RAM_WR_BLOCK,     // RAM write gate in reset
	output logic [PORT_W-1:0]         PORT_LATCH,       // port output latch reset
	output logic                      PORT_OPEN_DRAIN,  // port mode open-drain
	output logic                      PORT_WEAK_PU,     // weak pull-ups enabled
	output logic                      RETAIN_HOLD,      // freeze pins, dacs, ref
	output logic                      PC_CLEAR,         // clear program counter
	output logic [15:0]               START_ADDR,       // first fetch address
	output logic [1:0]                CLK_SEL,          // system clock source
	output logic                      GUARD_EN,         // guard timer enable
	output logic [2:0]                GUARD_TMO,        // guard timer interval
	output logic [SRC_COUNT-1:0]      RESET_CAUSE       // latched last cause
);

	// ==========================================
	// elaboration checks
	// the port vector needs at least one bit
	if (PORT_W < 1)
	begin : g_bad_port_w
		$error("rbd_top: PORT_W must be at least one");
	end
	// a zero stretch would let a glitching source bounce the core
	if (STRETCH_CYC < 1)
	begin : g_bad_stretch
		$error("rbd_top: STRETCH_CYC must be at least one");
	end

	localparam int CW = $clog2(STRETCH_CYC + 1);

	// ==========================================
	// all state in one record
	// s1 and s2 are the two synchroniser ranks of every source;
	// only s2 is ever read by the sequencing logic, so a
	// metastable first rank never reaches a decision
	typedef struct packed {
		logic [SRC_COUNT-1:0] s1;
		logic [SRC_COUNT-1:0] s2;
		rbd_state_t           st;
		logic [CW-1:0]        cnt;
		logic [SRC_COUNT-1:0] cause;
		logic                 pin_drive;
		logic                 retain_armed;
		logic                 halt;
		logic                 reg_rst;
		logic                 por_rst;
		logic                 hold_io;
		logic                 pc_clr;
		logic [15:0]          start;
		logic [1:0]           clk_sel;
		logic                 g_en;
		logic [2:0]           g_tmo;
		logic [PORT_W-1:0]    port_latch;
		logic                 port_od;
		logic                 port_wpu;
		logic                 pin_lvl;
	} rbd_state_s_t;

	rbd_state_s_t q;
	rbd_state_s_t d;

	logic [SRC_COUNT-1:0] src_raw;
	logic                 any_src;

	// ==========================================
	// source collection
	// every source is mapped to its fixed bit so the cause record
	// keeps the same layout for every reset type
	// the pin input is masked while we pull the pin ourselves;
	// otherwise our own drive would look like a button press
	// and the reset could never end
	// eight sources gathered
	always_comb
	begin
		src_raw             = '0;
		src_raw[SRC_POR]    = ~POR_N;
		src_raw[SRC_PIN]    = ~EXT_RESET_PIN_N_I & ~q.pin_drive;
		src_raw[SRC_CMP]    = CMP_RESET;
		src_raw[SRC_SW]     = SW_RESET;
		src_raw[SRC_SUPPLY] = SUPPLY_LOW;
		src_raw[SRC_GUARD]  = GUARD_OVF;
		src_raw[SRC_MCD]    = CLK_MISSING;
		src_raw[SRC_FLASH]  = FLASH_ERR;
	end

	// ORed into one request after synchronising
	assign any_src = |q.s2;

	// ==========================================
	// next state; the pin self-feedback is masked so our own drive never loops
	// run: wait for any synchronised source, then enter reset
	// hold: stay while any source is up, then count a quiet stretch
	// release: one cycle in which every reset output drops together
	// a source seen in the release cycle sends us back to hold,
	// so a late request is never lost
	always_comb
	begin
		d    = q;
		d.s1 = src_raw;
		d.s2 = q.s1;
		d.pc_clr = 1'b0;
		case (q.st)
			RBD_RUN:
			begin
				if (any_src)
				begin
					d.st    = RBD_HOLD;
					d.cause = q.s2;
					d.halt    = 1'b1;
					d.reg_rst = 1'b1;
					d.por_rst = q.s2[SRC_POR];
					// drive pin for power-on or supply
					// guard overflow leaves the pin alone
					d.pin_drive = q.s2[SRC_POR] | q.s2[SRC_SUPPLY];
					d.hold_io = q.retain_armed & ~q.s2[SRC_POR];
				end
			end
			RBD_HOLD:
			begin
				// causes accumulate; a power-on seen late still
				// clears retention and the power-on-only bits
				d.cause   = q.cause | q.s2;
				d.por_rst = q.por_rst | q.s2[SRC_POR];
				d.pin_drive = q.pin_drive | q.s2[SRC_POR] | q.s2[SRC_SUPPLY];
				if (q.s2[SRC_POR])
					d.hold_io = 1'b0;
				if (any_src)
					d.cnt = '0;
				else if (q.cnt == CW'(STRETCH_CYC))
					d.st = RBD_RELEASE;
				else
					d.cnt = q.cnt + CW'(1);
			end
			RBD_RELEASE:
			begin
				if (any_src)
				begin
					// late source: stay in reset, restart the stretch
					d.st        = RBD_HOLD;
					d.cnt       = '0;
					d.cause     = q.cause | q.s2;
					d.por_rst   = q.por_rst | q.s2[SRC_POR];
					d.pin_drive = q.pin_drive | q.s2[SRC_POR] | q.s2[SRC_SUPPLY];
					if (q.s2[SRC_POR])
						d.hold_io = 1'b0;
				end
				else
				begin
					// every register leaves reset on this edge
					d.st        = RBD_RUN;
					d.cnt       = '0;
					d.halt      = 1'b0;
					d.reg_rst   = 1'b0;
					d.por_rst   = 1'b0;
					d.pin_drive = 1'b0;
					d.hold_io   = 1'b0;
					d.pc_clr    = 1'b1;
					d.clk_sel   = CLK_SEL_INTERNAL;
					d.g_en      = 1'b1;
					d.g_tmo     = GUARD_TMO_MAX;
					// otherwise the reset vector
					// the byte is read once here, so a later flash
					// write cannot move the start of a running program
					if (BOOT_SIG == BOOT_SIG_PRESENT)
						d.start = BOOT_VECTOR;
					else
						d.start = RESET_VECTOR;
				end
			end
			default:
				d.st = RBD_HOLD;
		endcase
		// retention arm is firmware's choice, sampled only while running
		if (q.st == RBD_RUN && !any_src)
			d.retain_armed = RETAIN_EN;
		if (q.s2[SRC_POR])
			d.retain_armed = 1'b0;
	end

	// ==========================================
	// state register; reset lands in hold so a full reset cycle follows
	// the bench reset is treated as a power-on: cause, pin drive and
	// the power-on-only reset all come up as after a power cycle
	// all reset values are constants, nothing is read here
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			q           <= '0;
			q.st        <= RBD_HOLD;
			q.halt      <= 1'b1;
			q.reg_rst   <= 1'b1;
			q.por_rst   <= 1'b1;
			q.pin_drive <= 1'b1;
			q.cause     <= SRC_COUNT'(1) << SRC_POR;
			q.start     <= RESET_VECTOR;
			q.clk_sel   <= CLK_SEL_INTERNAL;
			q.g_en      <= 1'b1;
			q.g_tmo     <= GUARD_TMO_MAX;
			q.port_latch <= {PORT_W{PORT_LATCH_RST[0]}};
			q.port_od   <= 1'b1;
			q.port_wpu  <= 1'b1;
			q.pin_lvl   <= 1'b0;
		end
		else
			q <= d;
	end

	// ==========================================
	// outputs straight from state flops
	// the pin is open-drain: level is always low, only the enable moves,
	// so the board pull-up sets the level whenever we let go
	// interrupt, timer and RAM gates share the halt flop so they can
	// never disagree by a cycle at entry or exit
	assign EXT_RESET_PIN_N_O  = q.pin_lvl;
	assign EXT_RESET_PIN_N_OE = q.pin_drive;
	assign CORE_HALT          = q.halt;
	assign REG_RST            = q.reg_rst;
	assign REG_POR_RST        = q.por_rst;
	assign IRQ_DISABLE        = q.halt;
	assign TIMER_DISABLE      = q.halt;
	// RAM is never cleared, only write-gated
	assign RAM_WR_BLOCK       = q.halt;
	// latches one, open-drain, pull-ups on
	// held in flops that never change after reset; firmware owns
	// the real port registers, these only give their reset image
	assign PORT_LATCH         = q.port_latch;
	assign PORT_OPEN_DRAIN    = q.port_od;
	assign PORT_WEAK_PU       = q.port_wpu;
	assign RETAIN_HOLD        = q.hold_io;
	assign PC_CLEAR           = q.pc_clr;
	assign START_ADDR         = q.start;
	assign CLK_SEL            = q.clk_sel;
	assign GUARD_EN           = q.g_en;
	assign GUARD_TMO          = q.g_tmo;
	assign RESET_CAUSE        = q.cause;

endmodule

// file: verification/rbd_sva.sv
// port-level checker for the reset and boot dispatch block
// assumes one clock domain; bound to every rbd_top instance
`timescale 1ns/1ps
module rbd_sva
	import rbd_pkg::*;
#(
	parameter int          PORT_W      = 8,
	parameter logic [15:0] BOOT_VECTOR = BOOT_VECTOR_DEF
)
(
	input wire logic              CLK,                // system clock
	input wire logic              RST_B,              // sync reset, low
	input wire logic              POR_N,              // power-on detect
	input wire logic              SW_RESET,           // software request
	input wire logic              SUPPLY_LOW,         // supply trip
	input wire logic              GUARD_OVF,          // guard overflow
	input wire logic [7:0]        BOOT_SIG,           // signature byte
	input wire logic              EXT_RESET_PIN_N_O,  // pin level
	input wire logic              EXT_RESET_PIN_N_OE, // pin drive
	input wire logic              CORE_HALT,          // core stopped
	input wire logic              REG_RST,            // register reset
	input wire logic              IRQ_DISABLE,        // interrupts off
	input wire logic              TIMER_DISABLE,      // timers off
	input wire logic              RAM_WR_BLOCK,       // ram gate
	input wire logic [PORT_W-1:0] PORT_LATCH,         // port latch
	input wire logic              PORT_OPEN_DRAIN,    // port mode
	input wire logic              PORT_WEAK_PU,       // pull-ups
	input wire logic              PC_CLEAR,           // exit pulse
	input wire logic [15:0]       START_ADDR,         // first fetch
	input wire logic [1:0]        CLK_SEL,            // clock source
	input wire logic              GUARD_EN,           // guard enable
	input wire logic [2:0]        GUARD_TMO           // guard interval
);
	// ==========================================
	// assertions
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);

	chk_halt_gates: assert property (
		CORE_HALT |-> IRQ_DISABLE && TIMER_DISABLE && REG_RST && RAM_WR_BLOCK)
		else $error("reset outputs split from halt");
	chk_pc_pulse: assert property (
		$fell(CORE_HALT) |-> PC_CLEAR ##1 !PC_CLEAR)
		else $error("pc clear not a single exit pulse");
	chk_clock_guard: assert property (
		CLK_SEL == 2'h0 && GUARD_EN && GUARD_TMO == 3'h7)
		else $error("clock or guard defaults wrong");
	chk_port_idle: assert property (
		&PORT_LATCH && PORT_OPEN_DRAIN && PORT_WEAK_PU)
		else $error("port reset state wrong");
	chk_sw_entry: assert property (
		$rose(SW_RESET) && !CORE_HALT |-> ##[1:4] CORE_HALT)
		else $error("software request missed");
	chk_guard_pin: assert property (
		$rose(GUARD_OVF) && !EXT_RESET_PIN_N_OE && POR_N && !SUPPLY_LOW
		|=> !EXT_RESET_PIN_N_OE [*4])
		else $error("guard reset drove the pin");
	chk_supply_pin: assert property (
		$rose(SUPPLY_LOW) |-> ##[1:4] (EXT_RESET_PIN_N_OE && !EXT_RESET_PIN_N_O))
		else $error("supply reset left pin undriven");
	chk_pin_release: assert property (
		!CORE_HALT && !$past(CORE_HALT) |-> !EXT_RESET_PIN_N_OE)
		else $error("pin driven outside reset");
	chk_start_addr: assert property (
		$fell(CORE_HALT) |-> START_ADDR == (BOOT_SIG == 8'ha5 ? BOOT_VECTOR : 16'h0000))
		else $error("wrong start address");
endmodule

bind rbd_top rbd_sva #(.PORT_W(PORT_W), .BOOT_VECTOR(BOOT_VECTOR)) u_sva (.*);

// file: verification/rbd_board.sv
// board side model: supply rail, power-on detector, reset button, flash byte
// assumes a pull-up on the reset pin and requests from the bench
`timescale 1ns/1ps
module rbd_board
(
	input  wire logic       por,        // power cycle request
	input  wire logic       sag,        // supply dip request
	input  wire logic       press,      // button held low
	input  wire logic       boot,       // bootloader image loaded
	input  wire logic       oe,         // device drives the pin
	input  wire logic       o,          // device pin level
	output logic            por_n,      // power-on detector
	output logic            supply_low, // supply monitor trip
	output logic            pin_n,      // resolved pin level
	output logic [7:0]      sig         // signature byte
);
	// rail and detector follow the requests
	assign por_n = !por;
	assign supply_low = sag;
	// pull-up wins when nobody pulls low
	assign pin_n = oe ? o : !press;
	assign sig = boot ? 8'ha5 : 8'hff;
endmodule

// file: verification/rbd_tb.sv
// self-checking bench for rbd_top with board model and checker
// assumes package, checker and board model compiled first
`timescale 1ns/1ps
module tb;
	import rbd_pkg::*;
	logic        CLK = 0, RST_B = 0, RETAIN_EN = 1, boot = 0;
	logic [7:0]  req = 8'h00;
	logic        POR_N, EXT_RESET_PIN_N_I, SUPPLY_LOW, EXT_RESET_PIN_N_O, EXT_RESET_PIN_N_OE;
	logic        CORE_HALT, REG_RST, REG_POR_RST, IRQ_DISABLE, TIMER_DISABLE, RAM_WR_BLOCK;
	logic        PORT_OPEN_DRAIN, PORT_WEAK_PU, RETAIN_HOLD, PC_CLEAR, GUARD_EN;
	logic [7:0]  BOOT_SIG, PORT_LATCH, RESET_CAUSE;
	logic [15:0] START_ADDR;
	logic [1:0]  CLK_SEL;
	logic [2:0]  GUARD_TMO;
	int          n_errors = 0, num_checks = 0, i, k;
	wire CMP_RESET = req[2], SW_RESET = req[3], GUARD_OVF = req[5];
	wire CLK_MISSING = req[6], FLASH_ERR = req[7];

	// ==========================================
	// clock, design and board
	always #10 CLK = ~CLK;
	rbd_top #(.STRETCH_CYC(2)) DUT (.*);
	rbd_board board (.por(req[0]), .sag(req[4]), .press(req[1]), .boot(boot),
		.oe(EXT_RESET_PIN_N_OE), .o(EXT_RESET_PIN_N_O), .por_n(POR_N),
		.supply_low(SUPPLY_LOW), .pin_n(EXT_RESET_PIN_N_I), .sig(BOOT_SIG));

	// ==========================================
	// shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// bounded wait on the halt level, a hang ends the run
	task automatic wait_halt(input logic lvl);
		k = 0;
		while (CORE_HALT !== lvl && k < 40)
		begin
			@(negedge CLK);
			k++;
		end
		if (CORE_HALT !== lvl)
		begin
			n_errors++;
			end_sim();
		end
	endtask

	// ==========================================
	// scenarios
	task automatic t_sources();
		for (i = 0; i < 8; i++)
		begin
			@(negedge CLK);
			boot = i[0];
			req = 8'h01 << i;
			wait_halt(1'b1);
			repeat (2) @(negedge CLK);
			check({IRQ_DISABLE, TIMER_DISABLE, REG_RST, RAM_WR_BLOCK}, 16'hf);
			check(EXT_RESET_PIN_N_OE, i == 0 || i == 4);
			check(REG_POR_RST, i == 0);
			check(RETAIN_HOLD, i != 0);
			req = 8'h00;
			wait_halt(1'b0);
			check(PC_CLEAR, 1'b1);
			check(START_ADDR, boot ? BOOT_VECTOR_DEF : 16'h0000);
			check(RESET_CAUSE, 8'h01 << i);
			check({CLK_SEL, GUARD_EN, GUARD_TMO}, 6'h0f);
			check({PORT_LATCH, PORT_OPEN_DRAIN, PORT_WEAK_PU}, 10'h3ff);
			check(EXT_RESET_PIN_N_OE, 1'b0);
		end
	endtask
	// a second source inside the hold stretches the reset
	task automatic t_restart();
		@(negedge CLK);
		RETAIN_EN = 0;
		req = 8'h08;
		wait_halt(1'b1);
		check(RETAIN_HOLD, 1'b0);
		req = 8'h00;
		@(negedge CLK);
		req = 8'h80;
		repeat (3) @(negedge CLK);
		req = 8'h00;
		wait_halt(1'b0);
		check(k >= 4, 1'b1);
		check(RESET_CAUSE, 8'h88);
		RETAIN_EN = 1;
	endtask
	// bench reset in mid-run acts as a power-on
	task automatic t_midreset();
		@(negedge CLK);
		RST_B = 0;
		repeat (2) @(negedge CLK);
		check({CORE_HALT, EXT_RESET_PIN_N_OE, RESET_CAUSE}, 10'h301);
		RST_B = 1;
		wait_halt(1'b0);
		check(PC_CLEAR, 1'b1);
		check(START_ADDR, boot ? BOOT_VECTOR_DEF : 16'h0000);
	endtask

	initial
	begin
		repeat (10) @(negedge CLK);
		check({CORE_HALT, EXT_RESET_PIN_N_OE, RESET_CAUSE}, 10'h301);
		RST_B = 1;
		wait_halt(1'b0);
		t_sources();
		t_restart();
		t_midreset();
		end_sim();
	end
endmodule
